// File: bes_bus_sizer.sv
// Purpose: Splits core operands into word address plus lane selects and runs sized bus cycles
// Assumes: Bus pins come from outside the clock domain and are synchronised here
// Notes:   Write-back enhanced protocol is only flagged, not sequenced here
`timescale 1ns/1ps
module bes_bus_sizer #(
  parameter bit HALF_BUS = 1'b0  // Narrow 16-bit data bus variant
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Configuration
  input wire logic write_back_cfg_in,
  // Core request
  input wire logic req_valid_in,
  input wire logic req_write_in,
  input wire logic req_mem_in,
  input wire logic [31:0] req_addr_in,
  input wire bes_pkg::bes_len_e req_len_in,
  input wire logic [31:0] req_wdata_in,
  output logic req_ready_out,
  output logic done_out,
  output logic [31:0] rdata_out,
  output logic parity_err_out,
  output logic enhanced_mode_out,
  // Bus address and control
  output logic [29:0] word_address_out,
  output logic [3:0] lane_select_n_out,
  output logic cycle_start_out,
  output logic write_out,
  output logic mem_io_out,
  // Bus data, three-signal form
  input wire logic [31:0] data_in,
  output logic [31:0] data_out,
  output logic data_oe_out,
  input wire logic parity_low_in,
  input wire logic parity_high_in,
  output logic parity_low_out,
  output logic parity_high_out,
  output logic parity_oe_out,
  // Bus answers, active low
  input wire logic ready_n_in,
  input wire logic half_width_req_n_in,
  input wire logic byte_width_req_n_in
);
  import bes_pkg::*;

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  logic [36:0] pin_s1;  // First stage, read only by the second
  logic [36:0] pin_s2;  // Second stage, read by the logic

  // Two flops per pin; data is caught with its ready so both stay coherent
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      pin_s1 <= {5'h1f, 32'h0000_0000};
      pin_s2 <= {5'h1f, 32'h0000_0000};
    end else begin
      pin_s1 <= {ready_n_in, half_width_req_n_in, byte_width_req_n_in, parity_high_in, parity_low_in, data_in};
      pin_s2 <= pin_s1;
    end
  end

  logic rdy_s;         // Ready, active high
  logic [31:0] din_s;  // Read data
  assign rdy_s = ~pin_s2[36];
  assign din_s = pin_s2[31:0];

  // ==========================================================================
  // State
  // ==========================================================================
  bes_state_e st, next_st;
  logic piece, next_piece;                  // 1 while on the upper word of a split operand
  logic pend_low, next_pend_low;            // Lower word still to run
  logic [3:0] low_mask, next_low_mask;      // Lower word lanes, active high
  logic [29:0] base_word, next_base_word;   // Word holding the operand's first byte
  logic [1:0] offset, next_offset;          // Operand start within its word
  logic [1:0] guard, next_guard;            // Edges since strobe, hides stale ready
  logic [63:0] wbuf, next_wbuf;             // Write data aligned to two words
  logic [63:0] rbuf, next_rbuf;             // Read bytes gathered over two words
  logic [29:0] next_word_address;
  logic [3:0] next_lane_select_n;
  logic next_cycle_start, next_write, next_mem_io, next_req_ready, next_done;
  logic [31:0] next_rdata, next_data;
  logic next_data_oe, next_parity_err;

  // ==========================================================================
  // Size decode and lane stepping
  // ==========================================================================
  bes_size_e size;         // Port width of the cycle now ending
  logic [3:0] capture;     // Lanes carrying data this cycle
  logic [3:0] step_lanes_n;
  logic more;
  logic ack;               // Bus cycle ends on this edge

  // Requests sampled in each cycle; the narrow variant ignores them and always sizes to 16 bits
  assign size = HALF_BUS ? BES_SIZE_16 : bes_size_decode(pin_s2[35], pin_s2[34]);
  assign ack = (st == BES_ST_BUS) && (guard == 2'(BES_SYNC_LAT)) && rdy_s;

  bes_lane_step u_step (
    .lanes_n_in(lane_select_n_out),
    .size_in(size),
    .capture_out(capture),
    .next_lanes_n_out(step_lanes_n),
    .more_out(more)
  );

  // Write word for one piece: idle lanes carry zero; the narrow variant moves the upper lanes onto the low pins
  function automatic logic [31:0] drive_word(input logic [63:0] wb, input logic pc, input logic [3:0] ln);
    logic [31:0] w;
    logic [31:0] r;
    w = pc ? wb[63:32] : wb[31:0];
    for (int i = 0; i < BES_LANES; i++) begin
      r[i*8 +: 8] = ln[i] ? 8'h00 : w[i*8 +: 8];
    end
    if (HALF_BUS) begin
      r = (ln[1:0] == 2'b11) ? {16'h0000, r[31:16]} : {16'h0000, r[15:0]};
    end
    return r;
  endfunction

  // Word address of a piece; I/O space keeps only 64 KB of reach
  function automatic logic [29:0] place_word(input logic [29:0] w, input logic mem);
    return mem ? w : {16'h0000, w[BES_IO_WORD_W-1:0]};
  endfunction

  // ==========================================================================
  // Sequencer next state
  // ==========================================================================
  always_comb begin
    logic [7:0] span;
    logic [63:0] sh;
    logic [31:0] src;
    span = 8'h00;
    sh = 64'h0000_0000_0000_0000;
    src = din_s;
    next_st = st;
    next_piece = piece;
    next_pend_low = pend_low;
    next_low_mask = low_mask;
    next_base_word = base_word;
    next_offset = offset;
    next_guard = (guard == 2'(BES_SYNC_LAT)) ? guard : guard + 2'h1;
    next_wbuf = wbuf;
    next_rbuf = rbuf;
    next_word_address = word_address_out;
    next_lane_select_n = lane_select_n_out;
    next_cycle_start = 1'b0;
    next_write = write_out;
    next_mem_io = mem_io_out;
    next_req_ready = req_ready_out;
    next_done = 1'b0;
    next_rdata = rdata_out;
    next_parity_err = 1'b0;
    case (st)
      // Wait for a core request
      BES_ST_IDLE: begin
        // Ready while idle; the first edge after reset raises it
        next_req_ready = 1'b1;
        if (req_valid_in && req_ready_out) begin
          span = bes_span(req_len_in, req_addr_in[1:0]);
          next_base_word = req_addr_in[31:2];
          next_offset = req_addr_in[1:0];
          next_low_mask = span[3:0];
          next_wbuf = {32'h0000_0000, req_wdata_in} << {req_addr_in[1:0], 3'b000};
          next_rbuf = BES_BUF_RST;
          next_write = req_write_in;
          next_mem_io = req_mem_in;
          next_req_ready = 1'b0;
          next_cycle_start = 1'b1;
          next_guard = BES_GUARD_RST;
          next_st = BES_ST_BUS;
          // Operand crossing a word boundary: high-order word goes first
          if (span[7:4] != 4'h0) begin
            next_piece = 1'b1;
            next_pend_low = 1'b1;
            next_lane_select_n = ~span[7:4];
            next_word_address = place_word(req_addr_in[31:2] + 30'h1, req_mem_in);
          end else begin
            next_piece = 1'b0;
            next_pend_low = 1'b0;
            next_lane_select_n = ~span[3:0];
            next_word_address = place_word(req_addr_in[31:2], req_mem_in);
          end
        end
      end
      // Cycle on the bus, waiting for ready
      BES_ST_BUS: begin
        if (ack) begin
          // Narrow variant takes upper lanes from the low pins
          if (HALF_BUS && (capture[1:0] == 2'b00)) begin
            src = {din_s[15:0], din_s[15:0]};
          end
          for (int i = 0; i < BES_LANES; i++) begin
            if (capture[i] && !write_out) begin
              next_rbuf[{piece, 2'(i)}*8 +: 8] = src[i*8 +: 8];
            end
          end
          // Even parity on the two low bytes of the narrow bus
          if (HALF_BUS && !write_out) begin
            next_parity_err = (^{din_s[7:0], pin_s2[32]}) || (^{din_s[15:8], pin_s2[33]});
          end
          next_guard = BES_GUARD_RST;
          if (more) begin
            // Same word, fewer lanes
            next_lane_select_n = step_lanes_n;
            next_cycle_start = 1'b1;
          end else if (pend_low) begin
            // Now the lower word of a split operand
            next_piece = 1'b0;
            next_pend_low = 1'b0;
            next_lane_select_n = ~low_mask;
            next_word_address = place_word(base_word, mem_io_out);
            next_cycle_start = 1'b1;
          end else begin
            // Operand complete
            sh = next_rbuf >> {offset, 3'b000};
            next_rdata = sh[31:0];
            next_done = 1'b1;
            next_lane_select_n = BES_LANES_IDLE;
            next_req_ready = 1'b1;
            next_st = BES_ST_IDLE;
          end
        end
      end
      default: begin
        next_st = BES_ST_IDLE;
        next_req_ready = 1'b1;
      end
    endcase
    next_data_oe = next_write && (next_st == BES_ST_BUS);
    next_data = next_data_oe ? drive_word(next_wbuf, next_piece, next_lane_select_n) : BES_DATA_RST;
  end

  // ==========================================================================
  // Sequencer registers
  // ==========================================================================
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      st <= BES_ST_IDLE;
      piece <= 1'b0;
      pend_low <= 1'b0;
      low_mask <= 4'h0;
      base_word <= BES_WADDR_RST;
      offset <= 2'h0;
      guard <= BES_GUARD_RST;
      wbuf <= BES_BUF_RST;
      rbuf <= BES_BUF_RST;
      word_address_out <= BES_WADDR_RST;
      lane_select_n_out <= BES_LANES_IDLE;
      cycle_start_out <= 1'b0;
      write_out <= 1'b0;
      mem_io_out <= 1'b1;
      req_ready_out <= 1'b0;
      done_out <= 1'b0;
      rdata_out <= BES_DATA_RST;
      data_out <= BES_DATA_RST;
      data_oe_out <= 1'b0;
      parity_err_out <= 1'b0;
    end else begin
      st <= next_st;
      piece <= next_piece;
      pend_low <= next_pend_low;
      low_mask <= next_low_mask;
      base_word <= next_base_word;
      offset <= next_offset;
      guard <= next_guard;
      wbuf <= next_wbuf;
      rbuf <= next_rbuf;
      word_address_out <= next_word_address;
      lane_select_n_out <= next_lane_select_n;
      cycle_start_out <= next_cycle_start;
      write_out <= next_write;
      mem_io_out <= next_mem_io;
      req_ready_out <= next_req_ready;
      done_out <= next_done;
      rdata_out <= next_rdata;
      data_out <= next_data;
      data_oe_out <= next_data_oe;
      parity_err_out <= next_parity_err;
    end
  end

  // ==========================================================================
  // Protocol mode and write parity
  // ==========================================================================
  logic next_parity_low, next_parity_high, next_parity_oe;

  // Parity pins exist only on the narrow bus; elsewhere they stay quiet
  always_comb begin
    next_parity_low = HALF_BUS ? ^next_data[7:0] : 1'b0;
    next_parity_high = HALF_BUS ? ^next_data[15:8] : 1'b0;
    next_parity_oe = HALF_BUS && next_data_oe;
  end

  // Bus protocol follows the cache policy; enhanced only in write-back
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      enhanced_mode_out <= 1'b0;
      parity_low_out <= 1'b0;
      parity_high_out <= 1'b0;
      parity_oe_out <= 1'b0;
    end else begin
      enhanced_mode_out <= write_back_cfg_in;
      parity_low_out <= next_parity_low;
      parity_high_out <= next_parity_high;
      parity_oe_out <= next_parity_oe;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);

  logic [3:0] act_now;  // Active-high lanes on the bus
  assign act_now = ~lane_select_n_out;

  sequence cycle_ends_s;
    ack && more;
  endsequence

  sequence next_strobe_s;
    ##1 cycle_start_out;
  endsequence

  lanes_contig_a: assert property ((st == BES_ST_BUS) |->
    (act_now inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h6, 4'hc, 4'h7, 4'he, 4'hf}))
    else $error("lane selects not contiguous");

  addr_hold_a: assert property (cycle_ends_s |-> next_strobe_s ##0 $stable(word_address_out))
    else $error("word address moved inside sized cycles");

  byte_step_a: assert property ((ack && size == BES_SIZE_8) |=>
    (st == BES_ST_BUS) || (act_now == 4'h0))
    else $error("byte sizing step wrong");

  byte_drop_a: assert property ((ack && more && size == BES_SIZE_8) |=>
    (act_now == ($past(act_now) & ($past(act_now) - 4'h1))))
    else $error("byte sizing did not drop lowest lane");

  half_drop_a: assert property ((ack && more && size == BES_SIZE_16) |=>
    (act_now == {$past(act_now[3:2]), 2'b00}))
    else $error("half sizing did not keep upper lanes");

  full_single_a: assert property ((ack && size == BES_SIZE_32 && !pend_low) |=>
    done_out && (st == BES_ST_IDLE))
    else $error("unsized cycle did not finish");

  io_range_a: assert property ((st == BES_ST_BUS && !mem_io_out) |->
    (word_address_out[29:BES_IO_WORD_W] == 16'h0000))
    else $error("I/O address beyond 64 KB");

  wr_lanes_a: assert property (data_oe_out |->
    ((data_out & {{8{lane_select_n_out[3]}}, {8{lane_select_n_out[2]}},
      {8{lane_select_n_out[1]}}, {8{lane_select_n_out[0]}}}) == 32'h0000_0000) || HALF_BUS)
    else $error("write data on idle lane");

  mode_follow_a: assert property (##1 (enhanced_mode_out == $past(write_back_cfg_in)))
    else $error("protocol mode does not follow cache policy");

  size_pick_a: assert property ((st == BES_ST_BUS && !HALF_BUS && !pin_s2[34]) |->
    (size == BES_SIZE_8))
    else $error("byte request not taken as 8-bit");

  narrow_bus_a: assert property ((HALF_BUS && data_oe_out) |-> (data_out[31:16] == 16'h0000))
    else $error("narrow bus drove upper data");

endmodule // bes_bus_sizer

// File: bes_pkg.sv
// Purpose: Shared constants and types for the byte-enable bus sizing unit
// Assumes: 32-bit data bus split into four byte lanes, one clock domain
// Notes:   Lane selects are active low; a set bit means the lane is idle
package bes_pkg;

  // ==========================================================================
  // Bus geometry
  // ==========================================================================
  localparam int BES_LANES = 4;             // Byte lanes on the data bus
  localparam int BES_DATA_W = 32;           // Data bus width
  localparam int BES_WADDR_W = 30;          // Word address width, bits 31..2
  localparam int BES_IO_WORD_W = 14;        // I/O space word address width (64 KB)
  localparam int BES_SYNC_LAT = 2;          // Edges that a pin input spends in its synchroniser

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [3:0] BES_LANES_IDLE = 4'hf;                 // No lane selected
  localparam logic [29:0] BES_WADDR_RST = 30'h0000_0000;        // Word address after reset
  localparam logic [31:0] BES_DATA_RST = 32'h0000_0000;         // Data after reset
  localparam logic [63:0] BES_BUF_RST = 64'h0000_0000_0000_0000;// Two-word buffers after reset
  localparam logic [1:0] BES_GUARD_RST = 2'h0;                  // Ready guard count after reset

  // ==========================================================================
  // Types
  // ==========================================================================
  // Port width requested by the outside decode logic
  typedef enum logic [1:0] {BES_SIZE_32, BES_SIZE_16, BES_SIZE_8} bes_size_e;
  // Operand length from the core
  typedef enum logic [1:0] {BES_LEN_1, BES_LEN_2, BES_LEN_4} bes_len_e;
  // Sequencer states
  typedef enum logic {BES_ST_IDLE, BES_ST_BUS} bes_state_e;

  // ==========================================================================
  // Functions
  // ==========================================================================
  // Both requests, or the byte request alone, mean an 8-bit port
  function automatic bes_size_e bes_size_decode(input logic half_n, input logic byte_n);
    if (!byte_n) begin
      return BES_SIZE_8;
    end else if (!half_n) begin
      return BES_SIZE_16;
    end
    return BES_SIZE_32;
  endfunction

  // Operand bytes across two words, active high, bit 0 = lowest address
  function automatic logic [7:0] bes_span(input bes_len_e len, input logic [1:0] off);
    logic [7:0] m;
    case (len)
      BES_LEN_1: m = 8'h01;
      BES_LEN_2: m = 8'h03;
      default: m = 8'h0f;
    endcase
    return m << off;
  endfunction

endpackage

// File: bes_lane_step.sv
// Purpose: Works out which lanes carry data this cycle and which remain
// Assumes: Lane pattern is contiguous and not empty
// Notes:   Pure combinational, used once per completed bus cycle
`timescale 1ns/1ps
module bes_lane_step (
  // Current cycle
  input wire logic [3:0] lanes_n_in,
  input wire bes_pkg::bes_size_e size_in,
  // Result
  output logic [3:0] capture_out,
  output logic [3:0] next_lanes_n_out,
  output logic more_out
);
  import bes_pkg::*;

  logic [3:0] act;   // Active-high lanes
  logic [3:0] low;   // Lowest active lane
  logic [3:0] rest;  // Lanes left for a further cycle

  // ==========================================================================
  // Step logic
  // ==========================================================================
  always_comb begin
    act = ~lanes_n_in;
    low = act & (~act + 4'h1);
    case (size_in)
      // Byte port: lowest lane now, the rest later
      BES_SIZE_8: begin
        capture_out = low;
        rest = act & ~low;
      end
      // Half port: lower half first, upper half only if both halves used
      BES_SIZE_16: begin
        if (act[1:0] != 2'b00) begin
          capture_out = {2'b00, act[1:0]};
          rest = {act[3:2], 2'b00};
        end else begin
          capture_out = act;
          rest = 4'h0;
        end
      end
      // Full port: everything at once
      default: begin
        capture_out = act;
        rest = 4'h0;
      end
    endcase
    more_out = (rest != 4'h0);
    next_lanes_n_out = ~rest;
  end

endmodule // bes_lane_step

// File: bes_far_side.sv
// Purpose: Far side model: decoder, swap buffers and byte memory
// Assumes: One ready pulse per cycle, sizes held around it
// Notes:   Lines it does not drive carry a changing pattern
`timescale 1ns/1ps
module bes_far_side (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  // Scenario control: 0 wide, 1 half, 2 byte, 3 both
  input wire logic [1:0] size_mode_in,
  input wire logic slow_in,
  // Bus from the sizer
  input wire logic cycle_start_in,
  input wire logic write_in,
  input wire logic [29:0] word_address_in,
  input wire logic [3:0] lane_select_n_in,
  input wire logic [31:0] data_in,
  // Answers
  output logic [31:0] data_out,
  output logic ready_n_out,
  output logic half_width_req_n_out,
  output logic byte_width_req_n_out
);
  logic [7:0] mem [0:255]; // Bytes by word and lane
  logic [1:0] step; // Phase, 0 idle
  logic [1:0] wait_q; // Extra wait states
  logic [3:0] take; // Lanes this port serves
  logic [7:0] noise = 8'h00; // Moves every cycle, known from time zero
  logic [31:0] rd; // Steered read word
  initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'ha5;
  // ======
  // Steering: narrow ports serve lowest lane or lowest used half
  always_comb begin
    take = ~lane_select_n_in;
    if (size_mode_in[1]) take = take & (~take + 4'h1);
    else if (size_mode_in[0] && take[1:0] != 2'b00) take[3:2] = 2'b00;
    // Lane index stands in for the low address bits
    for (int i = 0; i < 4; i++) rd[8*i +: 8] = take[i] ? mem[{word_address_in[5:0], 2'(i)}] : ~noise;
  end
  // ======
  // Cycle answer, ready low for one clock
  always @(posedge sys_clk_in) begin
    noise <= noise + 8'h3b;
    if (rst_in) begin
      step <= 2'd0;
      ready_n_out <= 1'b1;
      half_width_req_n_out <= 1'b1;
      byte_width_req_n_out <= 1'b1;
      data_out <= {4{noise}};
    end else begin
      case (step)
        2'd0: if (cycle_start_in) begin
          // Size asked again in every cycle
          half_width_req_n_out <= ~size_mode_in[0];
          byte_width_req_n_out <= ~size_mode_in[1];
          data_out <= rd;
          wait_q <= slow_in ? 2'd3 : 2'd0;
          step <= 2'd1;
        end else data_out <= {4{noise}};
        2'd1: if (wait_q != 2'd0) wait_q <= wait_q - 2'd1;
        else begin
          ready_n_out <= 1'b0;
          step <= 2'd2;
        end
        2'd2: begin
          ready_n_out <= 1'b1;
          step <= 2'd3;
          for (int i = 0; i < 4; i++) if (write_in && take[i]) mem[{word_address_in[5:0], 2'(i)}] <= data_in[8*i +: 8];
        end
        default: begin
          // Held one clock past ready, then let go
          half_width_req_n_out <= 1'b1;
          byte_width_req_n_out <= 1'b1;
          data_out <= {4{noise}};
          step <= 2'd0;
        end
      endcase
    end
  end
endmodule // bes_far_side

// File: bes_bus_sizer_tb_top.sv
// Purpose: Self-checking bench for the bus sizer
// Assumes: Far side model answers every bus cycle
// Notes:   Expected lanes packed one nibble per cycle
`timescale 1ns/1ps
module bes_bus_sizer_tb_top;
  import bes_pkg::*;
  logic sys_clk_in = 0, rst_in = 1, wb = 0, vld = 0, wr = 0, mem = 1, slow = 0;
  logic [31:0] addr = 0, wd = 0, di, dout, pd, rdata;
  bes_len_e len = BES_LEN_4;
  logic [1:0] mode = 0; // Far side port width
  logic rdy, done, enh, cs, wo, mio, oe, hn, bn, rn, last_mio;
  logic [29:0] wa;
  logic [3:0] ln, act;
  int mismatches = 0, checked = 0;
  logic [3:0] q_ln [$]; // Lanes per cycle start
  logic [29:0] q_wa [$]; // Word address per cycle start
  always #10 sys_clk_in = ~sys_clk_in;
  assign di = oe ? dout : pd; // Bus level from both drivers
  bes_bus_sizer bes_bus_sizer_inst (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .write_back_cfg_in(wb),
    .req_valid_in(vld), .req_write_in(wr), .req_mem_in(mem), .req_addr_in(addr), .req_len_in(len),
    .req_wdata_in(wd), .req_ready_out(rdy), .done_out(done), .rdata_out(rdata), .parity_err_out(),
    .enhanced_mode_out(enh), .word_address_out(wa), .lane_select_n_out(ln), .cycle_start_out(cs),
    .write_out(wo), .mem_io_out(mio), .data_in(di), .data_out(dout), .data_oe_out(oe),
    .parity_low_in(1'b0), .parity_high_in(1'b0), .parity_low_out(), .parity_high_out(),
    .parity_oe_out(), .ready_n_in(rn), .half_width_req_n_in(hn), .byte_width_req_n_in(bn));
  bes_far_side bes_far_side_inst (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .size_mode_in(mode),
    .slow_in(slow), .cycle_start_in(cs), .write_in(wo), .word_address_in(wa), .lane_select_n_in(ln),
    .data_in(dout), .data_out(pd), .ready_n_out(rn), .half_width_req_n_out(hn), .byte_width_req_n_out(bn));
  // ======
  // Compare and verdict
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Log each cycle start; check lane run and write lanes
  always @(negedge sys_clk_in) if (cs === 1'b1) begin
    act = ~ln;
    q_ln.push_back(ln);
    q_wa.push_back(wa);
    last_mio = mio;
    check_val({31'h0, act != 4'h0 && ((act + (act & -act)) & act) == 4'h0}, 32'h1);
    if (wo === 1'b1) check_val(dout & ~{{8{act[3]}}, {8{act[2]}}, {8{act[1]}}, {8{act[0]}}}, 32'h0);
  end
  // ======
  // One operand: request, wait done, compare cycles
  task automatic run(input logic w, m, input logic [31:0] a, d, input logic [1:0] md, input int n,
      input logic [15:0] lanes, input logic [29:0] wa0, wa1, input logic [31:0] er);
    int k;
    @(posedge sys_clk_in);
    q_ln.delete();
    q_wa.delete();
    wr <= w;
    mem <= m;
    addr <= a;
    wd <= d;
    mode <= md;
    vld <= 1'b1;
    do @(negedge sys_clk_in); while (rdy !== 1'b1);
    @(posedge sys_clk_in);
    vld <= 1'b0;
    k = 0;
    do begin @(negedge sys_clk_in); k++; end while (done !== 1'b1 && k < 300);
    check_val({31'h0, done}, 32'h1);
    check_val(q_ln.size(), n);
    for (k = 0; k < n && k < q_ln.size(); k++) begin
      check_val(q_ln[k], lanes[4*k +: 4]);
      check_val(q_wa[k], k == 0 ? wa0 : wa1);
    end
    check_val(last_mio, m);
    if (!w) check_val(rdata, er);
  endtask
  // ======
  // Main sequence
  initial begin
    repeat (3) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    check_val(ln, 4'hf);
    run(0, 1, 32'h0000_0000, 0, 0, 1, 16'h0000, 0, 0, 32'ha6a7_a4a5);
    run(0, 1, 32'h0000_0000, 0, 1, 2, 16'h0030, 0, 0, 32'ha6a7_a4a5);
    run(0, 1, 32'h0000_0000, 0, 2, 4, 16'h7310, 0, 0, 32'ha6a7_a4a5);
    slow <= 1'b1;
    run(0, 1, 32'h0000_0000, 0, 3, 4, 16'h7310, 0, 0, 32'ha6a7_a4a5);
    slow <= 1'b0;
    run(1, 1, 32'h0000_0040, 32'h1122_3344, 1, 2, 16'h0030, 30'h10, 30'h10, 0);
    run(0, 1, 32'h0000_0040, 0, 2, 4, 16'h7310, 30'h10, 30'h10, 32'h1122_3344);
    run(0, 1, 32'h0000_0021, 0, 0, 2, 16'h001e, 30'h9, 30'h8, 32'h8186_8784);
    run(0, 0, 32'hffff_0010, 0, 0, 1, 16'h0000, 30'h4, 30'h4, 32'hb6b7_b4b5);
    for (int v = 1; v >= 0; v--) begin
      @(posedge sys_clk_in);
      wb <= v[0];
      @(posedge sys_clk_in);
      @(negedge sys_clk_in);
      check_val({31'h0, enh}, v);
    end
    final_report();
  end
  // Hang guard, far beyond the run's length
  initial begin
    #200_000;
    mismatches++;
    final_report();
  end
endmodule // bes_bus_sizer_tb_top
